// >>> hw/pbrc_top.v
// Control logic of the synthesizer: configuration words over APB, band search,
// phase resync, fast lock, output muting and the multipurpose test output.
// Assumes one 100 MHz clock; the reference period is a divided enable pulse and
// analog status (lock, band comparator, counters) arrives asynchronously.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "pbrc_map.vh"
module pbrc_top #(
    parameter PFD_DIV = 8,
    parameter BAND_SLOT = 16
) (
    input wire mclk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire mute_pin,
    input wire lock_in,
    input wire vco_too_slow,
    input wire ref_count_in,
    input wire fb_count_in,
    input wire sdo_data,
    output reg pd_polarity,
    output reg cp_tristate,
    output reg [1:0] vco_band,
    output reg vco_external,
    output reg [2:0] output_divider,
    output reg rf_output_enable,
    output reg [11:0] phase_offset,
    output reg feedback_from_divider,
    output reg phase_realign,
    output reg [3:0] pump_current_setting,
    output reg loop_damping_switch,
    output reg counter_load,
    output reg lock_detect_reset,
    output reg test_out,
    output reg test_out_oe
);
    // ==========================================================================
    // Local state codes
    localparam ST_IDLE = 2'b00;
    localparam ST_SLOT = 2'b01;
    localparam ST_NEXT = 2'b10;

    reg [31:0] w0;
    reg [31:0] w1;
    reg [31:0] w2;
    reg [31:0] w3;
    reg [31:0] w4;
    reg [31:0] w5;
    reg [31:0] w6;
    reg [31:0] w7;
    reg [11:0] act_phase;
    reg [31:0] act_den;
    reg [3:0] act_pcs;
    reg [15:0] pfd_cnt;
    reg pfd_tick;
    reg [1:0] cal_state;
    reg [15:0] slot_cnt;
    reg cal_start;
    reg resync_arm;
    reg resync_seen;
    reg fast_lock;
    reg w0_written;
    wire mute_s;
    wire lock_s;
    wire slow_s;
    wire refc_s;
    wire fbc_s;
    wire sync_pulse;
    wire wr_en;
    wire rd_en;
    wire addr_ok;
    wire skip;
    wire power_down;
    wire [1:0] resync_mode;
    wire [31:0] status;

    // Decode of a mapped word address
    function f_mapped;
        input [7:0] a;
        begin
            f_mapped = (a[1:0] == 2'b00) && (a <= `PBRC_ADDR_STATUS);
        end
    endfunction

    // ==========================================================================
    // Synchronisers for pins and analog status
    pbrc_sync3 u_mute (
        .mclk(mclk),
        .rst(rst),
        .async_in(mute_pin),
        .sync_out(mute_s)
    );
    pbrc_sync3 u_lock (
        .mclk(mclk),
        .rst(rst),
        .async_in(lock_in),
        .sync_out(lock_s)
    );
    pbrc_sync3 u_slow (
        .mclk(mclk),
        .rst(rst),
        .async_in(vco_too_slow),
        .sync_out(slow_s)
    );
    pbrc_sync3 u_refc (
        .mclk(mclk),
        .rst(rst),
        .async_in(ref_count_in),
        .sync_out(refc_s)
    );
    pbrc_sync3 u_fbc (
        .mclk(mclk),
        .rst(rst),
        .async_in(fb_count_in),
        .sync_out(fbc_s)
    );

    // ==========================================================================
    // APB slave: zero wait states, error on unmapped or read-only writes
    assign addr_ok = f_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_ok || (pwrite && paddr == `PBRC_ADDR_STATUS));
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && penable && !pwrite && addr_ok;

    assign skip = w1[`PBRC_SKIP_BIT];
    assign power_down = w2[`PBRC_PD_BIT];
    assign resync_mode = w7[`PBRC_RSM_HI:`PBRC_RSM_LO];
    assign status = {24'h00_0000, lock_s, fast_lock, resync_arm, (cal_state != ST_IDLE),
                     mute_s, power_down, vco_band};

    // Configuration words; input registers keep latching in power-down
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            w0 <= `PBRC_RST_W0;
            w1 <= `PBRC_RST_W1;
            w2 <= `PBRC_RST_W2;
            w3 <= `PBRC_RST_WORD;
            w4 <= `PBRC_RST_W4;
            w5 <= `PBRC_RST_WORD;
            w6 <= `PBRC_RST_WORD;
            w7 <= `PBRC_RST_WORD;
            w0_written <= 1'b0;
        end else begin
            w0_written <= 1'b0;
            if (wr_en) begin
                case (paddr)
                    `PBRC_ADDR_W0: begin
                        w0 <= pwdata;
                        w0_written <= 1'b1;
                    end
                    `PBRC_ADDR_W1: w1 <= pwdata;
                    `PBRC_ADDR_W2: w2 <= pwdata;
                    `PBRC_ADDR_W3: w3 <= pwdata;
                    `PBRC_ADDR_W4: w4 <= pwdata;
                    `PBRC_ADDR_W5: w5 <= pwdata;
                    `PBRC_ADDR_W6: w6 <= pwdata;
                    `PBRC_ADDR_W7: w7 <= pwdata;
                    default: w0_written <= 1'b0;
                endcase
            end
        end
    end

    // Read data, taken in the access cycle
    always @* begin
        case (paddr)
            `PBRC_ADDR_W0: prdata = w0;
            `PBRC_ADDR_W1: prdata = w1;
            `PBRC_ADDR_W2: prdata = w2;
            `PBRC_ADDR_W3: prdata = w3;
            `PBRC_ADDR_W4: prdata = w4;
            `PBRC_ADDR_W5: prdata = w5;
            `PBRC_ADDR_W6: prdata = w6;
            `PBRC_ADDR_W7: prdata = w7;
            `PBRC_ADDR_STATUS: prdata = status;
            default: prdata = 32'h0000_0000;
        endcase
        if (!rd_en) begin
            prdata = 32'h0000_0000;
        end
    end

    // ==========================================================================
    // Double-buffered fields take effect on a word 0 write
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_phase <= 12'h000;
            act_den <= 32'h0000_0001;
            act_pcs <= 4'h0;
        end else if (w0_written) begin
            act_phase <= w1[`PBRC_PHASE_HI:`PBRC_PHASE_LO];
            act_den <= {w1[`PBRC_MODH_HI:`PBRC_MODH_LO], w5[`PBRC_MODL_HI:`PBRC_MODL_LO]};
            act_pcs <= w2[`PBRC_PCS_HI:`PBRC_PCS_LO];
        end
    end

    // ==========================================================================
    // Reference-period enable from a divider of mclk
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pfd_cnt <= 16'h0000;
            pfd_tick <= 1'b0;
        end else if (pfd_cnt == PFD_DIV[15:0] - 16'h0001) begin
            pfd_cnt <= 16'h0000;
            pfd_tick <= 1'b1;
        end else begin
            pfd_cnt <= pfd_cnt + 16'h0001;
            pfd_tick <= 1'b0;
        end
    end

    // ==========================================================================
    // Band search request: once after reset, then per word 0 write unless skipped
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cal_start <= 1'b1;
        end else if (w0_written && !skip) begin
            cal_start <= 1'b1;
        end else if (cal_state == ST_IDLE) begin
            cal_start <= 1'b0;
        end
    end

    // Band search: start at lowest band, step up while the comparator says too slow
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cal_state <= ST_IDLE;
            slot_cnt <= 16'h0000;
            vco_band <= 2'h0;
        end else begin
            case (cal_state)
                ST_IDLE: begin
                    if (cal_start && !power_down) begin
                        vco_band <= 2'h0;
                        slot_cnt <= 16'h0000;
                        cal_state <= ST_SLOT;
                    end
                end
                ST_SLOT: begin
                    if (pfd_tick) begin
                        if (slot_cnt == BAND_SLOT[15:0] - 16'h0001) begin
                            cal_state <= ST_NEXT;
                        end else begin
                            slot_cnt <= slot_cnt + 16'h0001;
                        end
                    end
                end
                ST_NEXT: begin
                    slot_cnt <= 16'h0000;
                    if (slow_s && vco_band != `PBRC_BAND_LAST) begin
                        vco_band <= vco_band + 2'h1;
                        cal_state <= ST_SLOT;
                    end else begin
                        cal_state <= ST_IDLE;
                    end
                end
                default: cal_state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================================
    // Shared sync timer for resync and fast lock
    pbrc_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .pfd_tick(pfd_tick),
        .run(resync_arm || fast_lock),
        .clear(w0_written),
        .clk_div(w4[`PBRC_CDIV_HI:`PBRC_CDIV_LO]),
        .modulus(act_den),
        .sync_pulse(sync_pulse)
    );

    // Resync: second timer pulse after the word 0 write realigns the phase
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            resync_arm <= 1'b0;
            resync_seen <= 1'b0;
            phase_realign <= 1'b0;
        end else begin
            phase_realign <= 1'b0;
            if (w0_written) begin
                resync_arm <= !skip && (resync_mode == `PBRC_RSM_RESYNC);
                resync_seen <= 1'b0;
            end else if (resync_arm && sync_pulse) begin
                if (resync_seen) begin
                    resync_arm <= 1'b0;
                    phase_realign <= 1'b1;
                end else begin
                    resync_seen <= 1'b1;
                end
            end
        end
    end

    // Fast lock lasts from the word 0 write until the first timer pulse or power-down
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            fast_lock <= 1'b0;
        end else if (w0_written) begin
            fast_lock <= !skip && (resync_mode == `PBRC_RSM_FASTLOCK);
        end else if (sync_pulse || power_down) begin
            fast_lock <= 1'b0;
        end
    end

    // ==========================================================================
    // Loop, output and power-down controls
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pd_polarity <= 1'b1;
            cp_tristate <= 1'b1;
            vco_external <= 1'b0;
            output_divider <= 3'h0;
            rf_output_enable <= 1'b0;
            phase_offset <= 12'h000;
            feedback_from_divider <= 1'b0;
            pump_current_setting <= 4'h0;
            loop_damping_switch <= 1'b0;
            counter_load <= 1'b1;
            lock_detect_reset <= 1'b1;
        end else begin
            pd_polarity <= w2[`PBRC_POL_BIT];
            cp_tristate <= w2[`PBRC_CPZ_BIT] || power_down;
            vco_external <= w4[`PBRC_EXTV_BIT];
            output_divider <= w7[`PBRC_ODIV_HI:`PBRC_ODIV_LO];
            rf_output_enable <= w4[`PBRC_RFEN_BIT] && !power_down && !mute_s
                && !(w4[`PBRC_MLCK_BIT] && !lock_s);
            phase_offset <= act_phase;
            feedback_from_divider <= w4[`PBRC_FBK_BIT];
            pump_current_setting <= fast_lock ? `PBRC_PCS_MAX : act_pcs;
            loop_damping_switch <= fast_lock;
            counter_load <= power_down;
            lock_detect_reset <= power_down;
        end
    end

    // ==========================================================================
    // Multipurpose test output
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            test_out <= 1'b0;
            test_out_oe <= 1'b0;
        end else begin
            test_out_oe <= 1'b1;
            case (w2[`PBRC_TSEL_HI:`PBRC_TSEL_LO])
                `PBRC_TSEL_HIZ: begin
                    test_out <= 1'b0;
                    test_out_oe <= 1'b0;
                end
                `PBRC_TSEL_HIGH: test_out <= 1'b1;
                `PBRC_TSEL_LOW: test_out <= 1'b0;
                `PBRC_TSEL_REFC: test_out <= refc_s;
                `PBRC_TSEL_FBC: test_out <= fbc_s;
                `PBRC_TSEL_RSVD: test_out <= 1'b0;
                `PBRC_TSEL_LOCK: test_out <= lock_s && !power_down;
                `PBRC_TSEL_SDO: test_out <= sdo_data;
                default: test_out <= 1'b0;
            endcase
        end
    end
endmodule

// >>> hw/pbrc_map.vh
// Constants of the synthesizer control block: register map, field positions, codes.
// Assumes inclusion by bare name from the design files; definitions only.
//
// What this block does
// - Phase detector sense follows polarity bit D6 of word 2.
// - Word 2 bit D4 set puts charge pump into three-state.
// - VCO band chosen automatically at power-up and on every word 0 write with word 1 D28 clear and word 2 D5 clear.
// - Output divider fed by internal VCO or external input; output at divided rate.
// - Mute-till-lock in word 4 keeps output stage current off until lock.
// - Mute input pin asserted mutes output, like mute-till-lock.
// - Word 1 D28 set: no band selection, no resync after word 0 update.
// - D28 clear: band selection on word 0 update; resync when word 7 field is 10.
// - Twelve-bit output phase offset from word 1 bits D26 to D15.
// - Word 4 D23 routes VCO or output-divider signal into feedback.
// - Timer pulses every divider times modulus reference periods; serves fast lock too.
// - Timer uses the smaller of modulus and 4095.
// - Phase realigned on second timer pulse after programming completes.
// - Fast lock raises pump current to maximum and closes damping switch.
// - Test output selected by word 2 bits D28 to D26 with eight codes.
// - Power-down loads counters, three-states pump, resets lock detect, disables output.
`ifndef PBRC_MAP_VH
`define PBRC_MAP_VH

// ==========================================================================
// Register byte addresses
`define PBRC_ADDR_W0 8'h00
`define PBRC_ADDR_W1 8'h04
`define PBRC_ADDR_W2 8'h08
`define PBRC_ADDR_W3 8'h0C
`define PBRC_ADDR_W4 8'h10
`define PBRC_ADDR_W5 8'h14
`define PBRC_ADDR_W6 8'h18
`define PBRC_ADDR_W7 8'h1C
`define PBRC_ADDR_STATUS 8'h20

// ==========================================================================
// Reset values
`define PBRC_RST_W0 32'h0032_0000
`define PBRC_RST_W1 32'h0000_0008
`define PBRC_RST_W2 32'h0000_0040
`define PBRC_RST_W4 32'h0010_0400
`define PBRC_RST_WORD 32'h0000_0000

// ==========================================================================
// Field positions
`define PBRC_POL_BIT 6
`define PBRC_CPZ_BIT 4
`define PBRC_PD_BIT 5
`define PBRC_SKIP_BIT 28
`define PBRC_PHASE_HI 26
`define PBRC_PHASE_LO 15
`define PBRC_MODH_HI 14
`define PBRC_MODH_LO 3
`define PBRC_MODL_HI 22
`define PBRC_MODL_LO 3
`define PBRC_PCS_HI 12
`define PBRC_PCS_LO 9
`define PBRC_TSEL_HI 28
`define PBRC_TSEL_LO 26
`define PBRC_FBK_BIT 23
`define PBRC_CDIV_HI 31
`define PBRC_CDIV_LO 20
`define PBRC_MLCK_BIT 10
`define PBRC_EXTV_BIT 9
`define PBRC_RFEN_BIT 5
`define PBRC_RSM_HI 18
`define PBRC_RSM_LO 17
`define PBRC_ODIV_HI 14
`define PBRC_ODIV_LO 12

// ==========================================================================
// Codes and limits
`define PBRC_RSM_RESYNC 2'b10
`define PBRC_RSM_FASTLOCK 2'b01
`define PBRC_PCS_MAX 4'hF
`define PBRC_TIMER_MAX 12'hFFF
`define PBRC_BAND_LAST 2'h2
`define PBRC_TSEL_HIZ 3'h0
`define PBRC_TSEL_HIGH 3'h1
`define PBRC_TSEL_LOW 3'h2
`define PBRC_TSEL_REFC 3'h3
`define PBRC_TSEL_FBC 3'h4
`define PBRC_TSEL_RSVD 3'h5
`define PBRC_TSEL_LOCK 3'h6
`define PBRC_TSEL_SDO 3'h7

`endif

// >>> hw/pbrc_sync3.v
// Three-stage synchroniser for a level arriving from outside the mclk domain.
// Assumes the input may change at any time; the output moves only once stages two and
// three agree.
`timescale 1ns/1ns
module pbrc_sync3 (
    input wire mclk,
    input wire rst,
    input wire async_in,
    output reg sync_out
);
    reg s1;
    reg s2;
    reg s3;

    // ==========================================================================
    // Shift chain; first stage feeds only the second
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sync_out <= s3; // Accept once stable
            end
        end
    end
endmodule

// >>> hw/pbrc_timer.v
// Twelve-bit sync timer paced by the reference-period enable.
// Assumes pfd_tick is a one-cycle enable and clear restarts the period.
`timescale 1ns/1ns
module pbrc_timer (
    input wire mclk,
    input wire rst,
    input wire pfd_tick,
    input wire run,
    input wire clear,
    input wire [11:0] clk_div,
    input wire [31:0] modulus,
    output reg sync_pulse
);
    reg [11:0] inner;
    reg [11:0] outer;
    reg [11:0] den_eff;
    reg [11:0] div_eff;

    // Smaller of modulus and the counter ceiling, never zero
    always @* begin
        den_eff = (modulus > {20'h0_0000, `PBRC_TIMER_MAX}) ? `PBRC_TIMER_MAX : modulus[11:0];
        if (den_eff == 12'h000) begin
            den_eff = 12'h001;
        end
        div_eff = (clk_div == 12'h000) ? 12'h001 : clk_div;
    end

    // ==========================================================================
    // Nested count: divider times effective modulus reference periods
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            inner <= 12'h000;
            outer <= 12'h000;
            sync_pulse <= 1'b0;
        end else begin
            sync_pulse <= 1'b0;
            if (clear || !run) begin
                inner <= 12'h000;
                outer <= 12'h000;
            end else if (pfd_tick) begin
                if (inner == den_eff - 12'h001) begin
                    inner <= 12'h000;
                    if (outer == div_eff - 12'h001) begin
                        outer <= 12'h000;
                        sync_pulse <= 1'b1;
                    end else begin
                        outer <= outer + 12'h001;
                    end
                end else begin
                    inner <= inner + 12'h001;
                end
            end
        end
    end
endmodule

// >>> tb/pbrc_top_monitor.sv
// Checker on the ports of pbrc_top.
// Assumes one clock mclk and reset rst; bound below the module.
`timescale 1ns/1ns
module pbrc_top_monitor (
    input wire mclk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire mute_pin,
    input wire pd_polarity,
    input wire cp_tristate,
    input wire counter_load,
    input wire lock_detect_reset,
    input wire vco_external,
    input wire feedback_from_divider,
    input wire rf_output_enable,
    input wire phase_realign,
    input wire [3:0] pump_current_setting,
    input wire loop_damping_switch,
    input wire test_out,
    input wire test_out_oe
);
    logic wr_ok;
    logic [2:0] tsel_q;
    // ==========================================
    // Accepted writes and test select shadow
    assign wr_ok = psel && penable && pwrite && !pslverr;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tsel_q <= 3'h0;
        end else if (wr_ok && paddr == 8'h08) begin
            tsel_q <= pwdata[28:26];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================
    // Properties
    a_pol_follows: assert property (wr_ok && paddr == 8'h08 |=>
        ##1 pd_polarity == $past(pwdata[6], 2)) else $error("polarity wrong");
    a_pump_hiz: assert property (wr_ok && paddr == 8'h08 |=>
        ##1 cp_tristate == ($past(pwdata[4], 2) | $past(pwdata[5], 2))) else $error("pump hiz");
    a_pdown_load: assert property (wr_ok && paddr == 8'h08 |=> ##1
        counter_load == $past(pwdata[5], 2) && lock_detect_reset == $past(pwdata[5], 2))
        else $error("power-down wrong");
    a_fbk_select: assert property (wr_ok && paddr == 8'h10 |=> ##1
        feedback_from_divider == $past(pwdata[23], 2) && vco_external == $past(pwdata[9], 2))
        else $error("feedback or source select wrong");
    a_bad_refused: assert property (psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'b00)
        |-> pslverr) else $error("bad address accepted");
    a_realign_pulse: assert property (phase_realign |=> !phase_realign)
        else $error("realign too long");
    a_realign_late: assert property (wr_ok && paddr == 8'h00 |=> !phase_realign [*3])
        else $error("realign too early");
    a_fast_pump: assert property (loop_damping_switch |-> pump_current_setting == 4'hF)
        else $error("fast lock pump not max");
    a_mute_pin: assert property (mute_pin [*8] |-> !rf_output_enable)
        else $error("output not muted");
    a_test_hiz: assert property ($past(tsel_q) == 3'h0 |-> !test_out_oe)
        else $error("test out driven");
    a_test_level: assert property ($past(tsel_q) == 3'h1 |-> test_out_oe && test_out)
        else $error("test out not high");
    a_test_low: assert property ($past(tsel_q) == 3'h2 || $past(tsel_q) == 3'h5
        |-> test_out_oe && !test_out) else $error("test out not low");
    c_realign: cover property (phase_realign);
    c_fast: cover property (loop_damping_switch);
    c_refused: cover property (psel && penable && pslverr);
endmodule
bind pbrc_top pbrc_top_monitor mon (.*);

// >>> tb/pbrc_host.sv
// APB master standing in for the configuration host.
// Assumes mclk from the bench; changes signals only after rising edges.
`timescale 1ns/1ns
module pbrc_host (
    input wire mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer: setup, access held until pready, then release
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// >>> tb/pll_band_phase_resync_control_bench.sv
// Self-checking bench for pbrc_top with short counts.
// Assumes pbrc_host drives APB and the monitor is bound.
`timescale 1ns/1ns
module pll_band_phase_resync_control_bench;
    localparam int PFD = 2;
    logic mclk, rst, mute_pin, lock_in, vco_too_slow, ref_count_in, fb_count_in, sdo_data;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pd_polarity, cp_tristate, vco_external, rf_output_enable, feedback_from_divider;
    logic phase_realign, loop_damping_switch, counter_load, lock_detect_reset;
    logic test_out, test_out_oe;
    logic [1:0] vco_band;
    logic [2:0] output_divider;
    logic [11:0] phase_offset;
    logic [3:0] pump_current_setting;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    pbrc_top #(.PFD_DIV(PFD), .BAND_SLOT(2)) dut (.*);
    pbrc_host host (.*);
    // ==========================================
    // Clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            results();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task t_regs;
        logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
        logic [31:0] e[5] = '{32'h0032_0000, 32'h8, 32'h40, 32'h0, 32'h0010_0400};
        for (int i = 0; i < 5; i++) begin
            host.xfer(1'b0, a[i], 32'h0, rd, err);
            chk(rd, e[i], "reset value");
        end
        host.xfer(1'b0, 8'h24, 32'h0, rd, err);
        chk(err, 1'b1, "unmapped read");
        host.xfer(1'b1, 8'h20, 32'h0, rd, err);
        chk(err, 1'b1, "status write");
        $display("t_regs done");
    endtask
    task t_word2;
        logic [7:0] lvl = 8'b0100_1010;
        for (int c = 0; c < 8; c++) begin
            wr(8'h08, (32'(c) << 26) | (32'({c[2], c[0], c[1]}) << 4));
            repeat (3) @(negedge mclk);
            chk(pd_polarity, c[2], "polarity");
            chk(cp_tristate, c[0] | c[1], "pump hiz");
            chk(counter_load & lock_detect_reset, c[0], "power-down");
            chk(test_out_oe, c != 0, "test oe");
            if (c != 0) chk(test_out, lvl[c], "test level");
        end
        wr(8'h08, 32'h40);
        $display("t_word2 done");
    endtask
    task w4_step(input logic [31:0] w, input logic m, input logic lk, input logic erf);
        @(posedge mclk);
        mute_pin <= m;
        lock_in <= lk;
        wr(8'h10, w);
        repeat (10) @(negedge mclk);
        chk(rf_output_enable, erf, "rf enable");
        chk(feedback_from_divider, w[23], "feedback select");
        chk(vco_external, w[9], "external source");
        $display("w4_step done");
    endtask
    task t_band(input logic slow, input logic skip, input logic [1:0] eb);
        @(posedge mclk);
        vco_too_slow <= slow;
        wr(8'h04, {3'h0, skip, 28'h8});
        wr(8'h00, 32'h0032_0000);
        repeat (60) @(negedge mclk);
        chk(vco_band, eb, "vco band");
        $display("t_band done");
    endtask
    task t_sync(input int cd, input int md, input logic [1:0] rsm, input logic skip);
        int p, n;
        p = cd * (md < 4095 ? md : 4095) * PFD;
        n = 0;
        wr(8'h1C, {13'h0, rsm, 2'h0, 3'h5, 12'h0});
        wr(8'h14, 32'(md) << 3);
        wr(8'h10, (32'(cd) << 20) | 32'h20);
        wr(8'h04, {3'h0, skip, 1'b0, 12'hA5C, 15'h0});
        wr(8'h00, 32'h0032_0000);
        if (rsm == 2'b01) begin
            repeat (4) @(negedge mclk);
            chk(loop_damping_switch, 1'b1, "fast lock switch");
        end
        while (n < 3 * p + 40 && (rsm == 2'b10 ? phase_realign !== 1'b1
                                                 : loop_damping_switch !== 1'b0)) begin
            @(negedge mclk);
            n++;
        end
        chk(phase_offset, 12'hA5C, "phase offset");
        chk(output_divider, 3'h5, "output divider");
        if (skip) chk(n, 3 * p + 40, "no resync");
        else if (rsm == 2'b10) chk(n > 2 * p - 8 && n < 2 * p + 8, 1'b1, "resync");
        else chk(n > p - 8 && n < p + 8 && pump_current_setting === 4'h0, 1'b1, "fast end");
        $display("t_sync done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        rst = 1'b1;
        mute_pin = 1'b0;
        lock_in = 1'b1;
        vco_too_slow = 1'b0;
        ref_count_in = 1'b1;
        fb_count_in = 1'b0;
        sdo_data = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_word2();
        w4_step(32'h0010_0020, 1'b0, 1'b0, 1'b1);
        w4_step(32'h0010_0420, 1'b0, 1'b0, 1'b0);
        w4_step(32'h0010_0420, 1'b0, 1'b1, 1'b1);
        w4_step(32'h0010_0420, 1'b1, 1'b1, 1'b0);
        w4_step(32'h0090_0220, 1'b0, 1'b1, 1'b1);
        t_band(1'b1, 1'b0, 2'h2);
        t_band(1'b0, 1'b0, 2'h0);
        t_band(1'b1, 1'b1, 2'h0);
        t_sync(2, 3, 2'b10, 1'b0);
        t_sync(1, 5000, 2'b10, 1'b0);
        t_sync(2, 3, 2'b10, 1'b1);
        t_sync(2, 3, 2'b01, 1'b0);
        results();
    end
endmodule
